// file: rtl/bwd_watchdog.sv
/*
  Board watchdog: control port and hold-off port on a byte-wide host I/O
  access, fixed one-second timeout, CPU reset and NMI pulse outputs.
  Assumes i_io_wr / i_io_rd are one-cycle strobes synchronous to i_clk,
  with address and write data valid in the same cycle.
*/
`timescale 1ns/1ps

// Function
// - Control bit 0 set with bit 2 clear arms the CPU reset; the port answers at 0E0h or 1E0h.
// - Control bit 1 enables the NMI output on expiry when set and disables it when clear.
// - Control bit 2 reads back whether the timer has expired.
// - After reset the watchdog is disabled with neither reset nor NMI armed.
// - Writing the key 5Ah to the hold-off port at 0E1h or 1E1h restarts the timeout.
// - The timeout is fixed in hardware with no software selection.
module bwd_watchdog #(
  parameter int TIMEOUT_CYC = bwd_pkg::BWD_TIMEOUT_CYC,
  parameter int PULSE_CYC   = bwd_pkg::BWD_PULSE_CYC
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Host I/O access
  input  wire logic [9:0] i_io_addr,
  input  wire logic       i_io_wr,
  input  wire logic       i_io_rd,
  input  wire logic [7:0] i_io_wdata,
  output logic      [7:0] o_io_rdata,
  output logic            o_io_rvalid,
  // Watchdog actions
  output logic            o_cpu_reset,
  output logic            o_nmi
);

  // ------------------------------------------------------------
  // Derived sizes
  // ------------------------------------------------------------
  // Pulse counter just wide enough for the pulse length
  localparam int                 PULSE_W    = $clog2(PULSE_CYC + 1);
  localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYC);
  localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(1);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // A pulse needs at least one cycle
  if (PULSE_CYC < 1) begin : g_bad_pulse
    $error("bwd_watchdog: PULSE_CYC must be at least 1");
  end
  // Timer needs at least two cycles to count
  if (TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("bwd_watchdog: TIMEOUT_CYC must be at least 2");
  end
  // A pulse must end before the next expiry could start one
  if (TIMEOUT_CYC <= PULSE_CYC) begin : g_bad_ratio
    $error("bwd_watchdog: TIMEOUT_CYC must exceed PULSE_CYC");
  end

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // Individual address matches
  wire hit_ctrl_pri = (i_io_addr == bwd_pkg::BWD_CTRL_PRI);
  wire hit_ctrl_alt = (i_io_addr == bwd_pkg::BWD_CTRL_ALT);
  wire hit_hold_pri = (i_io_addr == bwd_pkg::BWD_HOLD_PRI);
  wire hit_hold_alt = (i_io_addr == bwd_pkg::BWD_HOLD_ALT);

  // Either address of a pair reaches the same port
  wire hit_ctrl     = hit_ctrl_pri || hit_ctrl_alt;
  wire hit_hold     = hit_hold_pri || hit_hold_alt;

  // Control write data fields and the refresh key
  wire wr_rst_en    = i_io_wdata[bwd_pkg::BWD_BIT_RST_EN];
  wire wr_nmi_en    = i_io_wdata[bwd_pkg::BWD_BIT_NMI_EN];
  wire wr_expired   = i_io_wdata[bwd_pkg::BWD_BIT_EXPIRED];
  wire key_ok       = (i_io_wdata == bwd_pkg::BWD_KEY);

  // Access strobes; other hold-off bytes fall through
  wire wr_ctrl      = i_io_wr && hit_ctrl;
  wire wr_hold      = i_io_wr && hit_hold;
  wire kick         = wr_hold && key_ok;
  wire rd_ctrl      = i_io_rd && hit_ctrl;

  // ------------------------------------------------------------
  // Control state
  // ------------------------------------------------------------
  logic               rst_en;
  logic               nmi_en;
  logic               expired;
  logic               elapsed;
  logic [PULSE_W-1:0] pulse_cnt;

  // Next values of the registers
  logic               next_rst_en;
  logic               next_nmi_en;
  logic               next_expired;
  logic [PULSE_W-1:0] next_pulse_cnt;
  logic               next_cpu_reset;
  logic               next_nmi;
  logic [7:0]         next_rdata;
  logic [7:0]         rd_val;

  // Timer runs while an action is enabled and the flag is clear
  wire armed   = rst_en || nmi_en;
  wire running = armed && !expired;
  // A key in the expiry cycle wins, so the restart is never lost
  wire fire    = elapsed && running && !kick;

  // Read image of the control port; unused bits read as zero
  always_comb begin
    rd_val                           = bwd_pkg::BWD_RD_IDLE;
    rd_val[bwd_pkg::BWD_BIT_RST_EN]  = rst_en;
    rd_val[bwd_pkg::BWD_BIT_NMI_EN]  = nmi_en;
    rd_val[bwd_pkg::BWD_BIT_EXPIRED] = expired;
  end

  // ------------------------------------------------------------
  // Timeout counter
  // ------------------------------------------------------------
  // Fixed timeout, no software selection
  bwd_timeout #(
    .CYCLES   (TIMEOUT_CYC)
  ) u_timeout (
    .i_clk    (i_clk),
    .i_rst_b  (i_rst_b),
    .i_run    (running),
    .i_restart(kick),
    .o_elapsed(elapsed)
  );

  // ------------------------------------------------------------
  // Next-value logic
  // ------------------------------------------------------------
  // Enable bits follow a control write, else hold
  assign next_rst_en    = wr_ctrl ? wr_rst_en : rst_en;
  assign next_nmi_en    = wr_ctrl ? wr_nmi_en : nmi_en;

  // Expiry sets the flag and wins over a clearing write
  assign next_expired   = fire    ? 1'h1 :
                          wr_ctrl ? wr_expired :
                                    expired;

  // Pulse counter status
  wire pulse_busy       = (pulse_cnt != '0);
  wire pulse_end        = (pulse_cnt == PULSE_LAST);

  // Pulse counter loads on expiry, then runs down to zero
  assign next_pulse_cnt = fire       ? PULSE_LOAD :
                          pulse_busy ? pulse_cnt - PULSE_LAST :
                                       pulse_cnt;

  // Actions rise on expiry as enabled, fall after the last pulse cycle
  assign next_cpu_reset = fire      ? rst_en :
                          pulse_end ? 1'h0 :
                                      o_cpu_reset;
  assign next_nmi       = fire      ? nmi_en :
                          pulse_end ? 1'h0 :
                                      o_nmi;

  // Read data only in the cycle after a control read
  assign next_rdata     = rd_ctrl ? rd_val : bwd_pkg::BWD_RD_IDLE;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Enable bits, cleared by reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rst_en  <= bwd_pkg::BWD_EN_RESET;
      nmi_en  <= bwd_pkg::BWD_EN_RESET;
    end else begin
      rst_en  <= next_rst_en;
      nmi_en  <= next_nmi_en;
    end
  end

  // Sticky expired flag
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      expired <= bwd_pkg::BWD_EN_RESET;
    end else begin
      expired <= next_expired;
    end
  end

  // Action pulse length counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pulse_cnt <= '0;
    end else begin
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // CPU reset output, straight from a flop
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_cpu_reset <= 1'h0;
    end else begin
      o_cpu_reset <= next_cpu_reset;
    end
  end

  // NMI output, straight from a flop
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_nmi <= 1'h0;
    end else begin
      o_nmi <= next_nmi;
    end
  end

  // Read answer, straight from flops
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_io_rdata  <= bwd_pkg::BWD_RD_IDLE;
      o_io_rvalid <= 1'h0;
    end else begin
      o_io_rdata  <= next_rdata;
      o_io_rvalid <= rd_ctrl;
    end
  end

endmodule

// file: rtl/bwd_pkg.sv
/*
  Constants for the board watchdog: I/O port addresses, control bit
  positions, refresh key, reset values and the fixed timeout.
  Assumes a byte-wide host I/O port access with a 10-bit address.
*/
package bwd_pkg;

  // --------------------------------------------------------------
  // Port addresses
  // --------------------------------------------------------------
  localparam logic [9:0] BWD_CTRL_PRI    = 10'h0e0;
  localparam logic [9:0] BWD_CTRL_ALT    = 10'h1e0;
  localparam logic [9:0] BWD_HOLD_PRI    = 10'h0e1;
  localparam logic [9:0] BWD_HOLD_ALT    = 10'h1e1;

  // --------------------------------------------------------------
  // Control port fields
  // --------------------------------------------------------------
  localparam int         BWD_BIT_RST_EN  = 0;
  localparam int         BWD_BIT_NMI_EN  = 1;
  localparam int         BWD_BIT_EXPIRED = 2;
  localparam logic [7:0] BWD_KEY         = 8'h5a;
  localparam logic       BWD_EN_RESET    = 1'b0;
  localparam logic [7:0] BWD_RD_IDLE     = 8'h00;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int         BWD_CLK_HZ      = 40_000_000;
  localparam int         BWD_TIMEOUT_MS  = 1000;
  localparam int         BWD_TIMEOUT_CYC = (BWD_CLK_HZ / 1000) * BWD_TIMEOUT_MS;
  localparam int         BWD_PULSE_CYC   = 16;

endpackage

// file: rtl/bwd_timeout.sv
/*
  Gated, restartable down-counter for the watchdog timeout.
  Assumes the parent drives a restart pulse and a run level.
*/
`timescale 1ns/1ps

module bwd_timeout #(
  parameter int CYCLES = 40_000_000
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Control
  input  wire logic i_run,
  input  wire logic i_restart,
  // Status
  output logic      o_elapsed
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES - 1);

  // Refuse a period the counter cannot time
  if (CYCLES < 2) begin : g_bad_cycles
    $error("bwd_timeout: CYCLES must be at least 2");
  end

  logic [W-1:0] count;
  wire          at_zero = (count == '0);

  // Reload on restart or while stopped, else count down
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || i_restart || !i_run) begin
      count     <= LOAD;
      o_elapsed <= 1'b0;
    end else begin
      count     <= at_zero ? LOAD : count - 1'b1;
      o_elapsed <= at_zero;
    end
  end

endmodule

// file: tb/bwd_chk_assertions.sv
/* Port checker for bwd_watchdog.
   Assumes PULSE_CYC of 16 and the bind below. */
`timescale 1ns/1ps
module bwd_chk (
  // Watched ports
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic [9:0] i_io_addr,
  input wire logic       i_io_wr,
  input wire logic       i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  input wire logic       o_io_rvalid,
  input wire logic       o_cpu_reset,
  input wire logic       o_nmi
);
  // Port decode
  wire ctl = i_io_addr == bwd_pkg::BWD_CTRL_PRI || i_io_addr == bwd_pkg::BWD_CTRL_ALT;
  wire hld = i_io_addr == bwd_pkg::BWD_HOLD_PRI || i_io_addr == bwd_pkg::BWD_HOLD_ALT;
  wire key = i_io_wr && hld && i_io_wdata == bwd_pkg::BWD_KEY;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Port rules
  property p_rv; i_io_rd && ctl |=> o_io_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no read answer");
  property p_nrv; !(i_io_rd && ctl) |=> !o_io_rvalid; endproperty
  a_nrv: assert property (p_nrv) else $error("stray read answer");
  property p_hi; o_io_rvalid |-> o_io_rdata[7:3] == 5'h00; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_init; $rose(i_rst_b) |-> !o_cpu_reset && !o_nmi; endproperty
  a_init: assert property (p_init) else $error("armed after reset");
  property p_rpw; $rose(o_cpu_reset) |-> ##15 o_cpu_reset ##1 !o_cpu_reset; endproperty
  a_rpw: assert property (p_rpw) else $error("reset pulse width");
  property p_npw; $rose(o_nmi) |-> o_nmi[*8] ##1 o_nmi[*8] ##1 !o_nmi; endproperty
  a_npw: assert property (p_npw) else $error("nmi pulse width");
  property p_key; key |=> (!$rose(o_cpu_reset) && !$rose(o_nmi))[*8]; endproperty
  a_key: assert property (p_key) else $error("expiry after refresh");
  property p_idle; !o_io_rvalid |-> o_io_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle read data");
endmodule
bind bwd_watchdog bwd_chk bwd_chk_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_io_addr(i_io_addr),
  .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
  .o_io_rvalid(o_io_rvalid), .o_cpu_reset(o_cpu_reset), .o_nmi(o_nmi));

// file: tb/bwd_host.sv
/* Host model: byte I/O cycles at the falling edge.
   Assumes the read answer one cycle after the strobe. */
`timescale 1ns/1ps
module bwd_host (
  // Clock and answer
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  // Access
  output logic      [9:0] o_addr = 10'h000,
  output logic            o_wr = 1'b0,
  output logic            o_rd = 1'b0,
  output logic      [7:0] o_wdata = 8'h00
);
  // One-cycle write, then lines scrambled
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  // One-cycle read, answer taken next cycle
  task automatic rd(input logic [9:0] a, output logic [8:0] r);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    r = {i_rvalid, i_rdata};
  endtask
endmodule

// file: tb/bwd_watchdog_tb.sv
/* Bench for bwd_watchdog, 20-cycle timeout.
   Assumes bwd_host and the bound checker. */
`timescale 1ns/1ps
module bwd_watchdog_tb;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [8:0] r;
  wire  [9:0] addr;
  wire  [7:0] wd;
  wire  [7:0] rdata;
  wire        wr, rd, rv, cres, nmi;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_res = 0;
  int n_nmi = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  always @(posedge cres) n_res++;
  always @(posedge nmi) n_nmi++;
  bwd_watchdog #(.TIMEOUT_CYC(20), .PULSE_CYC(16)) bwd_watchdog_inst (.i_clk(clk), .i_rst_b(rst_b),
    .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wd), .o_io_rdata(rdata),
    .o_io_rvalid(rv), .o_cpu_reset(cres), .o_nmi(nmi));
  bwd_host h (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rv), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wd));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Compare action pulse counts
  task automatic chk_cnt(input int exp_res, input int exp_nmi);
    n_compared++;
    if (n_res != exp_res || n_nmi != exp_nmi) begin
      n_mismatch++;
      $display("wrong value at %0t: pulses %0d/%0d want %0d/%0d", $time, n_res, n_nmi, exp_res, exp_nmi);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    h.rd(bwd_pkg::BWD_CTRL_PRI, r); chk(r, 9'h100);
    h.wr(bwd_pkg::BWD_HOLD_PRI, 8'h5a);
    h.wr(bwd_pkg::BWD_CTRL_ALT, r[7:0] | 8'h01);
    h.rd(bwd_pkg::BWD_CTRL_PRI, r); chk(r, 9'h101);
    repeat (4) begin
      repeat (10) @(negedge clk);
      h.wr(bwd_pkg::BWD_HOLD_ALT, 8'h5a);
    end
    chk_cnt(0, 0);
    h.wr(bwd_pkg::BWD_HOLD_PRI, 8'ha5);
    repeat (20) @(negedge clk);
    chk_cnt(1, 0);
    h.rd(bwd_pkg::BWD_CTRL_ALT, r); chk(r, 9'h105);
    h.wr(bwd_pkg::BWD_CTRL_PRI, (r[7:0] & 8'hfa) | 8'h02);
    repeat (30) @(negedge clk);
    chk_cnt(1, 1);
    h.rd(bwd_pkg::BWD_HOLD_PRI, r); chk(r, 9'h000);
    h.rd(bwd_pkg::BWD_CTRL_ALT, r); chk(r, 9'h106);
    h.wr(bwd_pkg::BWD_CTRL_ALT, (r[7:0] & 8'hfb) | 8'h01);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    h.rd(bwd_pkg::BWD_CTRL_PRI, r); chk(r, 9'h100);
    repeat (30) @(negedge clk);
    chk_cnt(1, 1);
    wrap_up();
  end
endmodule
